// *** rtl/clkgen_pkg.sv ***
package clkgen_pkg;
  // Register byte offsets inside the block
  localparam logic [7:0] MODE_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h20;
  localparam logic [7:0] CLOCK_CTL_OFFSET = 8'h28;
  localparam int ADDR_BITS = 8;

  // Clock control register fields
  localparam int FREQ_LSB = 0;
  localparam int FREQ_W = 6;
  localparam int IMMEDIATE_BIT = 6;
  localparam int VIDEO_EN_BIT = 7;
  localparam int VIDEO_SEL_BIT = 8;
  localparam int COMM_EN_BIT = 9;
  localparam int CLOCK_CTL_W = 16;
  localparam logic [15:0] CLOCK_CTL_RESET = 16'h001b;
  localparam logic [5:0] FREQ_RESET = 6'h1b;

  // Power mode register fields
  localparam int MODE_SEL_W = 3;
  localparam int WAKE_ALLOW_BIT = 3;
  localparam logic [3:0] MODE_REG_RESET = 4'h1;

  // Status register fields
  localparam int ST_FAST_LOCK = 0;
  localparam int ST_VIDEO_LOCK = 1;
  localparam int ST_COMM_LOCK = 2;
  localparam int ST_MODE_LSB = 3;
  localparam int ST_PENDING = 6;
  localparam int ST_BUS_OWNED = 7;
  localparam int ST_CORE_MUTED = 8;

  // Nominal frequencies in Hz, kept exact for reading the codes
  localparam int FAST_MIN_HZ = 49766400;
  localparam int FAST_MAX_HZ = 82944000;
  localparam int FAST_DEFAULT_HZ = 70041600;
  localparam int VIDEO_LOW_HZ = 24883200;
  localparam int VIDEO_HIGH_HZ = 41472000;
  localparam int VIDEO_DEFAULT_HZ = 30412800;
  localparam int COMM_HZ = 48000000;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_RUN = 3'b000,
    MODE_SLOW = 3'b001,
    MODE_IDLE = 3'b010,
    MODE_SLEEP = 3'b011,
    MODE_DEEP = 3'b100
  } pm_mode_t;
endpackage : clkgen_pkg

// *** rtl/pll_gate.sv ***
`timescale 1ns/100ps
// Clock gate for one PLL output: open while enabled and locked, or while forced on
module pll_gate (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic enable,
  input wire logic lock,
  input wire logic force_on,
  output logic gate_q
);
  logic gate_d;

  // Test mode forces the clock through; otherwise lock must be seen
  assign gate_d = force_on | (enable & lock);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_q <= 1'b0;
    end else if (ce) begin
      gate_q <= gate_d;
    end
  end
endmodule : pll_gate

// *** rtl/power_manager_clock_generator.sv ***
`timescale 1ns/100ps
// What this block does
// - Core clock from fast PLL, six-bit frequency code, reset default code.
// - Immediate bit set: frequency writes go straight to the fast PLL.
// - Immediate bit clear: new code held until deep sleep entry.
// - Waking from deep sleep, fast PLL runs at the held code.
// - Bus clock is the core clock divided by two.
// - Video clock from video PLL, two selectable rates, reset default.
// - Video PLL disabled during system reset or deep sleep.
// - Derived clocks gated off while PLL outputs are unknown.
// - Clocks stay available in test modes; hresetn shuts every gate, system reset the video and comm ones only outside test mode.
// - Register slave on the bus; bus master to stop the core clock.
// - Five operating modes: run, slow, idle, sleep or deep sleep.
// - Comm PLL disabled in reset or deep sleep until software re-enables.
// - Slow mode runs the processor at the bus clock rate.
module power_manager_clock_generator (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic system_reset_n,
  input wire logic test_mode,
  input wire logic fast_pll_lock,
  input wire logic video_pll_lock,
  input wire logic comm_pll_lock,
  input wire logic wake_event,
  input wire logic cpu_interrupt,
  input wire logic bus_grant,
  output logic [5:0] fast_pll_freq,
  output logic fast_pll_run,
  output logic video_pll_enable,
  output logic video_pll_freq_select,
  output logic comm_pll_enable,
  output logic core_clock_gate,
  output logic video_clock_gate,
  output logic comm_clock_gate,
  output logic bus_clock,
  output logic cpu_fastbus_mode,
  output logic bus_request,
  output logic cpu_clock_stop
);
  // Bus address phase capture
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;

  // Software visible state
  logic [15:0] clock_ctl_q;
  logic [15:0] clock_ctl_d;
  logic wake_allow_q;
  logic [5:0] applied_freq_q;
  logic [5:0] applied_freq_d;
  logic pending_q;
  logic pending_d;
  logic mute_q;
  logic mute_d;
  logic lock_prev_q;
  logic bus_clock_q;
  logic video_en_q;
  logic comm_en_q;
  logic fastbus_q;
  logic bus_req_q;
  logic cpu_stop_q;

  clkgen_pkg::pm_mode_t mode_q;
  clkgen_pkg::pm_mode_t mode_d;
  clkgen_pkg::pm_mode_t target_q;
  clkgen_pkg::pm_mode_t target_d;

  // Address decode for the current address phase
  wire addr_valid = hsel & hready & (htrans == clkgen_pkg::HTRANS_NONSEQ |
                                      htrans == clkgen_pkg::HTRANS_SEQ);
  wire [7:0] addr_low = haddr[clkgen_pkg::ADDR_BITS-1:0];
  wire rd_access = addr_valid & ~hwrite;
  wire wr_access = addr_valid & hwrite;

  // Data phase write strobes
  wire wr_clock_ctl = wr_pend_q & (wr_addr_q == clkgen_pkg::CLOCK_CTL_OFFSET);
  wire wr_mode = wr_pend_q & (wr_addr_q == clkgen_pkg::MODE_OFFSET);

  // Fields of the incoming write word
  wire [5:0] new_freq = hwdata[clkgen_pkg::FREQ_LSB +: clkgen_pkg::FREQ_W];
  wire [2:0] new_mode = hwdata[clkgen_pkg::MODE_SEL_W-1:0];
  wire imm_write = wr_clock_ctl & hwdata[clkgen_pkg::IMMEDIATE_BIT];
  wire deep_now = (mode_q == clkgen_pkg::MODE_DEEP);

  // Deep sleep entry happens on the step from sleep to deep sleep
  wire deep_entry = (mode_q == clkgen_pkg::MODE_SLEEP) &
                    (target_q == clkgen_pkg::MODE_DEEP);
  wire wake_ok = wake_event & wake_allow_q;
  wire active_mode = (mode_q == clkgen_pkg::MODE_RUN) | (mode_q == clkgen_pkg::MODE_SLOW);

  // Video and comm PLLs drop out under reset or deep sleep
  wire pll_kill = ~system_reset_n | deep_now;

  // Read mux; unmapped offsets read zero
  wire [31:0] status_word = {23'h000000,
                             mute_q,
                             bus_req_q & bus_grant,
                             pending_q,
                             mode_q,
                             comm_pll_lock,
                             video_pll_lock,
                             fast_pll_lock};
  wire [31:0] clock_ctl_word = {16'h0000, clock_ctl_q};
  wire [31:0] mode_word = {28'h0000000, wake_allow_q, mode_q};
  wire [31:0] rdata_d = (addr_low == clkgen_pkg::CLOCK_CTL_OFFSET) ? clock_ctl_word :
                        (addr_low == clkgen_pkg::STATUS_OFFSET) ? status_word :
                        (addr_low == clkgen_pkg::MODE_OFFSET) ? mode_word :
                        32'h00000000;

  // Address phase registers; the slave never inserts wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h00000000;
    end else if (ce) begin
      wr_pend_q <= wr_access;
      wr_addr_q <= addr_low;
      if (rd_access) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // Clock control register; freq field and flags are plain storage
  assign clock_ctl_d = wr_clock_ctl ? hwdata[clkgen_pkg::CLOCK_CTL_W-1:0] :
                       clock_ctl_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_ctl_q <= clkgen_pkg::CLOCK_CTL_RESET;
    end else if (ce) begin
      clock_ctl_q <= clock_ctl_d;
    end
  end

  // Frequency actually on the PLL pins: direct, or held for deep sleep
  always_comb begin
    applied_freq_d = applied_freq_q;
    pending_d = pending_q;
    if (imm_write) begin
      applied_freq_d = new_freq;
      pending_d = 1'b0;
    end else if (wr_clock_ctl) begin
      pending_d = (new_freq != applied_freq_q);
    end else if (deep_entry & pending_q) begin
      applied_freq_d = clock_ctl_q[clkgen_pkg::FREQ_LSB +: clkgen_pkg::FREQ_W];
      pending_d = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      applied_freq_q <= clkgen_pkg::FREQ_RESET;
      pending_q <= 1'b0;
    end else if (ce) begin
      applied_freq_q <= applied_freq_d;
      pending_q <= pending_d;
    end
  end

  // Mute holds off the core gate until lock rises again
  // Lock falling is not awaited: the rising edge alone reopens
  assign mute_d = imm_write ? 1'b1 :
                  (fast_pll_lock & ~lock_prev_q) ? 1'b0 : mute_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mute_q <= 1'b0;
      lock_prev_q <= 1'b0;
    end else if (ce) begin
      mute_q <= mute_d;
      lock_prev_q <= fast_pll_lock;
    end
  end

  // Mode state machine: idle takes the bus, sleep passes on to deep
  always_comb begin
    mode_d = mode_q;
    target_d = target_q;
    unique case (mode_q)
      clkgen_pkg::MODE_RUN,
      clkgen_pkg::MODE_SLOW: begin
        if (wr_mode) begin
          unique case (new_mode)
            clkgen_pkg::MODE_RUN: mode_d = clkgen_pkg::MODE_RUN;
            clkgen_pkg::MODE_SLOW: mode_d = clkgen_pkg::MODE_SLOW;
            clkgen_pkg::MODE_IDLE,
            clkgen_pkg::MODE_SLEEP,
            clkgen_pkg::MODE_DEEP: begin
              mode_d = clkgen_pkg::MODE_IDLE;
              target_d = clkgen_pkg::pm_mode_t'(new_mode);
            end
            default: mode_d = mode_q;
          endcase
        end
      end
      clkgen_pkg::MODE_IDLE: begin
        if (cpu_interrupt) begin
          mode_d = clkgen_pkg::MODE_RUN;
          target_d = clkgen_pkg::MODE_RUN;
        end else if (bus_grant & target_q != clkgen_pkg::MODE_IDLE) begin
          mode_d = clkgen_pkg::MODE_SLEEP;
        end
      end
      clkgen_pkg::MODE_SLEEP: begin
        if (wake_ok) begin
          mode_d = clkgen_pkg::MODE_SLOW;
          target_d = clkgen_pkg::MODE_SLOW;
        end else if (target_q == clkgen_pkg::MODE_DEEP) begin
          mode_d = clkgen_pkg::MODE_DEEP;
        end
      end
      clkgen_pkg::MODE_DEEP: begin
        if (wake_ok) begin
          mode_d = clkgen_pkg::MODE_SLOW;
          target_d = clkgen_pkg::MODE_SLOW;
        end
      end
      default: begin
        mode_d = clkgen_pkg::MODE_SLOW;
        target_d = clkgen_pkg::MODE_SLOW;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= clkgen_pkg::MODE_SLOW;
      target_q <= clkgen_pkg::MODE_SLOW;
      wake_allow_q <= 1'b1;
    end else if (ce) begin
      mode_q <= mode_d;
      target_q <= target_d;
      if (wr_mode & active_mode) begin
        wake_allow_q <= hwdata[clkgen_pkg::WAKE_ALLOW_BIT];
      end
    end
  end

  // Enables follow software but are dropped by reset or deep sleep
  // Nothing restores them: software must write the bit again
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      video_en_q <= 1'b0;
      comm_en_q <= 1'b0;
    end else if (ce) begin
      if (pll_kill) begin
        video_en_q <= 1'b0;
        comm_en_q <= 1'b0;
      end else if (wr_clock_ctl) begin
        video_en_q <= hwdata[clkgen_pkg::VIDEO_EN_BIT];
        comm_en_q <= hwdata[clkgen_pkg::COMM_EN_BIT];
      end
    end
  end

  // Core side outputs: slow mode flag, bus master request, core stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fastbus_q <= 1'b1;
      bus_req_q <= 1'b0;
      cpu_stop_q <= 1'b0;
    end else if (ce) begin
      fastbus_q <= (mode_d == clkgen_pkg::MODE_SLOW);
      bus_req_q <= ~(mode_d == clkgen_pkg::MODE_RUN | mode_d == clkgen_pkg::MODE_SLOW);
      cpu_stop_q <= bus_req_q & bus_grant;
    end
  end

  // Bus clock toggles on each core edge while the core gate is open
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_clock_q <= 1'b0;
    end else if (ce & core_clock_gate) begin
      bus_clock_q <= ~bus_clock_q;
    end
  end

  // One gate per PLL; test mode keeps every clock running
  pll_gate u_core_gate (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .enable(~deep_now & ~mute_q),
    .lock(fast_pll_lock),
    .force_on(test_mode),
    .gate_q(core_clock_gate)
  );

  pll_gate u_video_gate (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .enable(video_en_q),
    .lock(video_pll_lock),
    .force_on(test_mode),
    .gate_q(video_clock_gate)
  );

  pll_gate u_comm_gate (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .enable(comm_en_q),
    .lock(comm_pll_lock),
    .force_on(test_mode),
    .gate_q(comm_clock_gate)
  );

  // Video select follows the control register bit, reaching its pin on the write edge even while disabled
  logic video_sel_q;
  logic fast_run_q;
  logic hresp_q;
  logic hready_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      video_sel_q <= 1'b0;
      fast_run_q <= 1'b1;
      hresp_q <= 1'b0;
      hready_q <= 1'b1;
    end else if (ce) begin
      video_sel_q <= clock_ctl_d[clkgen_pkg::VIDEO_SEL_BIT];
      fast_run_q <= ~(mode_d == clkgen_pkg::MODE_DEEP);
      hresp_q <= 1'b0;
      hready_q <= 1'b1;
    end
  end

  // Output wiring, each from a flop
  assign hrdata = rdata_q;
  assign hreadyout = hready_q;
  assign hresp = hresp_q;
  assign fast_pll_freq = applied_freq_q;
  assign fast_pll_run = fast_run_q;
  assign video_pll_enable = video_en_q;
  assign video_pll_freq_select = video_sel_q;
  assign comm_pll_enable = comm_en_q;
  assign bus_clock = bus_clock_q;
  assign cpu_fastbus_mode = fastbus_q;
  assign bus_request = bus_req_q;
  assign cpu_clock_stop = cpu_stop_q;
endmodule : power_manager_clock_generator

// *** bench/clkgen_asserts.sv ***
`timescale 1ns/100ps
// Port-level checks of the clock generator
module clkgen_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic test_mode,
  input wire logic fast_pll_lock,
  input wire logic system_reset_n,
  input wire logic bus_grant,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic video_pll_enable,
  input wire logic comm_pll_enable,
  input wire logic core_clock_gate,
  input wire logic video_clock_gate,
  input wire logic comm_clock_gate,
  input wire logic bus_clock,
  input wire logic bus_request,
  input wire logic cpu_clock_stop
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Bus answers and clock division
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not zero wait okay");
  bus_divide_a: assert property (ce && core_clock_gate |=> bus_clock != $past(bus_clock))
    else $error("bus clock missed a toggle");
  // Core clock stop follows the granted request by one cycle
  stop_follows_a: assert property (ce |=> cpu_clock_stop == $past(bus_request && bus_grant))
    else $error("core clock stop not tied to grant");
  // Gating against unknown PLL outputs, test override
  test_open_a: assert property (ce && test_mode |=> core_clock_gate && video_clock_gate
    && comm_clock_gate) else $error("test mode left a gate shut");
  unlocked_shut_a: assert property (ce && !test_mode && !fast_pll_lock |=> !core_clock_gate)
    else $error("core gate open while unlocked");
  video_gate_a: assert property (ce && !test_mode && !video_pll_enable |=> !video_clock_gate)
    else $error("video gate open while disabled");
  gate_cause_a: assert property ($rose(core_clock_gate) |-> $past(fast_pll_lock || test_mode))
    else $error("core gate opened without lock");
  // System reset kills the video and comm enables
  sysrst_kill_a: assert property (ce && !system_reset_n |=> !video_pll_enable
    && !comm_pll_enable) else $error("enable survived system reset");

  cover property (cpu_clock_stop);
  cover property (test_mode && core_clock_gate && !fast_pll_lock);
  cover property ($fell(video_pll_enable));
endmodule : clkgen_checker

bind power_manager_clock_generator clkgen_checker chk (.hclk, .hresetn, .ce, .test_mode,
  .fast_pll_lock, .system_reset_n, .bus_grant, .hreadyout, .hresp, .video_pll_enable,
  .comm_pll_enable, .core_clock_gate, .video_clock_gate, .comm_clock_gate, .bus_clock,
  .bus_request, .cpu_clock_stop);

// *** bench/cpu_model.sv ***
`timescale 1ns/100ps
// Processor side: word transfers and a bus grant with a settable lag
module cpu_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hready,
  input wire logic bus_request,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic rd_take,
  output logic bus_grant
);
  int lag = 0;
  int cnt;
  int stalls = 0;

  initial begin
    {hsel, haddr, htrans, hwrite, hsize, hwdata, rd_take} = '0;
  end

  // Bounded wait for an edge with ready high; a miss is counted
  task automatic ready_edge();
    bit seen;
    seen = 1'b0;
    for (int i = 0; i < 64 && !seen; i++) begin
      @(posedge hclk);
      seen = (hready === 1'b1);
    end
    if (!seen) stalls++;
  endtask : ready_edge

  // Address phase held until ready, then data phase held until ready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= clkgen_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= clkgen_pkg::HSIZE_WORD;
    ready_edge();
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~haddr; // Released lines never show a stale value
    hwdata <= d;
    rd_take <= !w;
    ready_edge();
    hwdata <= ~d;
    rd_take <= 1'b0;
  endtask : xfer

  // Grant after lag cycles, dropped with the request
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_grant <= 1'b0;
      cnt <= 0;
    end else if (!bus_request) begin
      bus_grant <= 1'b0;
      cnt <= 0;
    end else if (cnt >= lag) begin
      bus_grant <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : cpu_model

// *** bench/power_manager_clock_generator_bench.sv ***
`timescale 1ns/100ps
module power_manager_clock_generator_bench;
  localparam logic [31:0] CORE_G = 32'h8000;
  localparam logic [31:0] VID_G = 32'h4000;
  localparam logic [31:0] REQ = 32'h1000;
  localparam logic [31:0] STOP = 32'h0800;
  localparam logic [31:0] FBUS = 32'h0400;
  localparam logic [31:0] RUN = 32'h0200;
  localparam logic [31:0] VEN = 32'h0100;
  localparam logic [31:0] VSEL = 32'h0080;
  localparam logic [31:0] CEN = 32'h0040;
  localparam logic [31:0] FREQ = 32'h003f;
  localparam logic [7:0] CTL = clkgen_pkg::CLOCK_CTL_OFFSET;
  localparam logic [7:0] MODE = clkgen_pkg::MODE_OFFSET;
  logic hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, rd_take, b;
  logic system_reset_n, test_mode, fast_pll_lock, video_pll_lock, comm_pll_lock;
  logic wake_event, cpu_interrupt, bus_grant, fast_pll_run, video_pll_enable;
  logic video_pll_freq_select, comm_pll_enable, core_clock_gate, video_clock_gate;
  logic comm_clock_gate, bus_clock, cpu_fastbus_mode, bus_request, cpu_clock_stop;
  logic [31:0] haddr, hwdata, hrdata, e, m;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [5:0] fast_pll_freq, code, code2;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int miscompares = 0;
  int n_tests = 0;

  power_manager_clock_generator dut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .system_reset_n,
    .test_mode, .fast_pll_lock, .video_pll_lock, .comm_pll_lock, .wake_event, .cpu_interrupt,
    .bus_grant, .fast_pll_freq, .fast_pll_run, .video_pll_enable, .video_pll_freq_select,
    .comm_pll_enable, .core_clock_gate, .video_clock_gate, .comm_clock_gate, .bus_clock,
    .cpu_fastbus_mode, .bus_request, .cpu_clock_stop);
  cpu_model cpu (.hclk, .hresetn, .hready(hreadyout), .bus_request, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .rd_take, .bus_grant);

  // 200 MHz clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // Output pins packed for masked comparison
  function automatic logic [31:0] pins();
    return {16'h0, core_clock_gate, video_clock_gate, comm_clock_gate, bus_request,
      cpu_clock_stop, cpu_fastbus_mode, fast_pll_run, video_pll_enable, video_pll_freq_select,
      comm_pll_enable, fast_pll_freq};
  endfunction : pins

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] ev);
    n_tests++;
    if (seen !== ev) begin
      miscompares++;
      $display("Error %0t: saw %h expected %h", $time, seen, ev);
    end
  endtask : check

  // Settled sampling one step after an edge
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : settle

  task automatic pin(input logic [31:0] mv, input logic [31:0] ev);
    check(pins() & mv, ev);
  endtask : pin

  // Bounded wait; running out counts and ends the run
  task automatic poll(input logic [31:0] mv, input logic [31:0] ev);
    int i;
    #1;
    for (i = 0; i < 64 && (pins() & mv) !== ev; i++) settle(1);
    check(pins() & mv, ev);
    if (i == 64) give_verdict();
  endtask : poll

  // A bus answer that never came counts and ends the run
  task automatic bus_guard();
    if (cpu.stalls != 0) begin
      miscompares += cpu.stalls;
      $display("Error %0t: bus answer timed out", $time);
      give_verdict();
    end
  endtask : bus_guard

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cpu.xfer(1'b1, a, d);
    bus_guard();
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [31:0] mv);
    exp_q.push_back(ev);
    msk_q.push_back(mv);
    cpu.xfer(1'b0, a, 32'h0);
    bus_guard();
  endtask : rd

  // Read data matched against the oldest noted expectation
  always @(posedge hclk) begin
    if (rd_take === 1'b1 && hreadyout === 1'b1) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      check(hrdata & m, e);
    end
  end

  // Whole-run limit
  initial begin
    repeat (20000) @(posedge hclk);
    $display("Error %0t: run limit reached", $time);
    miscompares++;
    give_verdict();
  end

  initial begin
    {hresetn, ce, system_reset_n, test_mode, fast_pll_lock} = 5'b01100;
    {video_pll_lock, comm_pll_lock, wake_event, cpu_interrupt} = 4'h0;
    void'($urandom(32'hc9ae));
    code = 6'($urandom_range(63, 0));
    code2 = ~code;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    // Defaults out of reset, core gate shut while unlocked, unmapped reads zero
    settle(1);
    pin(FREQ | CORE_G | VEN | RUN | FBUS, 32'h1b | RUN | FBUS);
    rd(CTL, 32'h1b, 32'hffff);
    rd(MODE, 32'h9, 32'hf);
    rd(8'h10, 32'h0, 32'hffffffff);
    // Lock arrives: core gate opens, bus clock halves
    @(posedge hclk) {fast_pll_lock, video_pll_lock, comm_pll_lock} <= 3'b111;
    settle(2);
    pin(CORE_G | VID_G, CORE_G);
    b = bus_clock;
    settle(1);
    check({31'h0, bus_clock}, {31'h0, ~b});
    // Immediate code goes to the pins and mutes the core clock until relock
    wr(CTL, {25'h0, 1'b1, code});
    pin(FREQ, {26'h0, code});
    settle(3);
    pin(CORE_G, 32'h0);
    @(posedge hclk) fast_pll_lock <= 1'b0;
    @(posedge hclk) fast_pll_lock <= 1'b1;
    poll(CORE_G, CORE_G);
    // Deferred code held until deep sleep, with a slow grant
    wr(CTL, {22'h0, 4'b1110, code2});
    pin(FREQ | VEN | VSEL | CEN, {26'h0, code} | VEN | VSEL | CEN);
    rd(clkgen_pkg::STATUS_OFFSET, 32'h40, 32'h40);
    cpu.lag = 3;
    wr(MODE, 32'hc);
    poll(RUN, 32'h0);
    settle(1); // Enables drop one edge after deep sleep begins
    pin(FREQ | STOP | VEN | CEN, {26'h0, code2} | STOP);
    // Wake event stands in for the timer wake; comes back in slow mode
    @(posedge hclk) {wake_event, fast_pll_lock} <= 2'b10;
    poll(RUN | REQ | FBUS, RUN | FBUS);
    pin(FREQ | VEN, {26'h0, code2});
    @(posedge hclk) {wake_event, fast_pll_lock} <= 2'b01;
    rd(MODE, 32'h1, 32'h7);
    // Software re-enables, then changes video rate off, select, on
    cpu.lag = 0;
    wr(CTL, {22'h0, 4'b1010, code2});
    wr(CTL, {22'h0, 4'b1100, code2});
    wr(CTL, {22'h0, 4'b1110, code2});
    pin(VEN | VSEL, VEN | VSEL);
    settle(1);
    pin(VID_G, VID_G);
    @(posedge hclk) system_reset_n <= 1'b0;
    settle(2);
    pin(VEN | CEN | VID_G, 32'h0);
    @(posedge hclk) system_reset_n <= 1'b1;
    // Idle until interrupt, then run; then back to slow mode
    wr(MODE, 32'ha);
    poll(REQ, REQ);
    @(posedge hclk) cpu_interrupt <= 1'b1;
    poll(REQ | FBUS, 32'h0);
    @(posedge hclk) cpu_interrupt <= 1'b0;
    wr(MODE, 32'h9);
    poll(FBUS, FBUS);
    // Plain sleep: parked with the bus owned until a wake event
    wr(MODE, 32'hb);
    poll(STOP, STOP);
    rd(clkgen_pkg::STATUS_OFFSET, 32'h98, 32'h1b8);
    @(posedge hclk) wake_event <= 1'b1;
    poll(REQ | FBUS | RUN, FBUS | RUN);
    @(posedge hclk) wake_event <= 1'b0;
    wr(MODE, 32'hf);
    rd(MODE, 32'h9, 32'hf);
    // Test mode opens every gate with fast and video lock low
    @(posedge hclk) {test_mode, fast_pll_lock, video_pll_lock} <= 3'b100;
    settle(2);
    pin(CORE_G | VID_G | 32'h2000, CORE_G | VID_G | 32'h2000);
    give_verdict();
  end
endmodule : power_manager_clock_generator_bench
